/* hdl/ald_alu.v */
`timescale 1ns/1ps
`include "ald_map.vh"

module ald_alu
(
  input  wire [11:0] instr,
  input  wire [7:0]  fval,
  input  wire [7:0]  wval,
  input  wire        c_in,
  input  wire        cin_dis,
  output reg  [7:0]  res,
  output reg         c_out,
  output reg         dc_out,
  output wire        z_out,
  output reg         wr_file,
  output reg         wr_acc,
  output reg         upd_z,
  output reg         upd_c,
  output reg         upd_dc,
  output reg         skip,
  output reg         wdt_clr
);

  // 9-bit sum of two bytes and a carry in
  function [8:0] add9;
    input [7:0] a;
    input [7:0] b;
    input       ci;
    begin
      add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    end
  endfunction

  wire [7:0] lit = instr[7:0];
  reg  [8:0] sum;
  reg  [8:0] nib;

  assign z_out = ~|res;

  always @*
  begin
    res     = fval;
    c_out   = c_in;
    dc_out  = 1'b0;
    wr_file = 1'b0;
    wr_acc  = 1'b0;
    upd_z   = 1'b0;
    upd_c   = 1'b0;
    upd_dc  = 1'b0;
    skip    = 1'b0;
    wdt_clr = 1'b0;
    sum     = 9'h000;
    nib     = 9'h000;
    if (instr[11:8] == `ALD_OP_ANDL)
    begin
      res = wval & lit; wr_acc = 1'b1; upd_z = 1'b1;
    end
    else if (instr[11:8] == `ALD_OP_ORL)
    begin
      res = wval | lit; wr_acc = 1'b1; upd_z = 1'b1;
    end
    else if (instr[11:8] == `ALD_OP_XORL)
    begin
      res = wval ^ lit; wr_acc = 1'b1; upd_z = 1'b1;
    end
    else if (instr == `ALD_OP_CLRWDT)
      wdt_clr = 1'b1;
    else
    begin
      case (instr[11:5])
        `ALD_OP_ANDF:  begin res = fval & wval; wr_file = 1'b1; upd_z = 1'b1; end
        `ALD_OP_ANDW:  begin res = fval & wval; wr_acc = 1'b1; upd_z = 1'b1; end
        `ALD_OP_NOTF:  begin res = fval ^ 8'hff; wr_file = 1'b1; upd_z = 1'b1; end
        `ALD_OP_ORF:   begin res = fval | wval; wr_file = 1'b1; upd_z = 1'b1; end
        `ALD_OP_ORW:   begin res = fval | wval; wr_acc = 1'b1; upd_z = 1'b1; end
        `ALD_OP_XORF:  begin res = fval ^ wval; wr_file = 1'b1; upd_z = 1'b1; end
        `ALD_OP_XORW:  begin res = fval ^ wval; wr_acc = 1'b1; upd_z = 1'b1; end
        `ALD_OP_ADDF, `ALD_OP_ADDW, `ALD_OP_SUBF:
        begin
          if (instr[11:5] == `ALD_OP_SUBF)
          begin
            // f - w - ~c as f + ~w + c; forced +1 when carry-in is off
            sum = add9(fval, ~wval, cin_dis | c_in);
            nib = add9({4'h0, fval[3:0]}, {4'h0, ~wval[3:0]}, cin_dis | c_in);
          end
          else
          begin
            sum = add9(fval, wval, ~cin_dis & c_in);
            nib = add9({4'h0, fval[3:0]}, {4'h0, wval[3:0]}, ~cin_dis & c_in);
          end
          res     = sum[7:0];
          c_out   = sum[8];
          dc_out  = nib[4];
          wr_file = (instr[11:5] != `ALD_OP_ADDW);
          wr_acc  = (instr[11:5] == `ALD_OP_ADDW);
          upd_z   = 1'b1;
          upd_c   = 1'b1;
          upd_dc  = 1'b1;
        end
        `ALD_OP_DECF:  begin res = fval - 8'h01; wr_file = 1'b1; upd_z = 1'b1; end
        `ALD_OP_DECSKIP: begin res = fval - 8'h01; wr_file = 1'b1; skip = (fval == 8'h01); end
        `ALD_OP_INCF:  begin res = fval + 8'h01; wr_file = 1'b1; upd_z = 1'b1; end
        `ALD_OP_INCSKIP: begin res = fval + 8'h01; wr_file = 1'b1; skip = (fval == 8'hff); end
        `ALD_OP_RLF:
        begin
          res = {fval[6:0], c_in}; c_out = fval[7]; wr_file = 1'b1; upd_c = 1'b1;
        end
        `ALD_OP_RRF:
        begin
          res = {c_in, fval[7:1]}; c_out = fval[0]; wr_file = 1'b1; upd_c = 1'b1;
        end
        `ALD_OP_SWAPF: begin res = {fval[3:0], fval[7:4]}; wr_file = 1'b1; end
        default:       res = fval;
      endcase
    end
  end

endmodule // ald_alu

/* hdl/ald_core.v */
// Functional notes
// - Each instruction commits in one instruction cycle; a skip costs one more.
// - Config word bit 11 at zero makes the instruction clock equal pclk.
// - AND file with accumulator into file; zero flag updated.
// - AND accumulator with file into accumulator; zero flag updated.
// - AND accumulator with literal into accumulator; zero flag updated.
// - Complement file register in place; zero flag updated.
// - OR file with accumulator into file; zero flag updated.
// - OR accumulator with file into accumulator; zero flag updated.
// - OR accumulator with literal into accumulator; zero flag updated.
// - XOR file with accumulator into file; zero flag updated.
// - XOR accumulator with file into accumulator; zero flag updated.
// - XOR accumulator with literal into accumulator; zero flag updated.
// - Add accumulator to file, carry in unless disabled; C, nibble carry, Z.
// - Add file to accumulator, carry in unless disabled; C, nibble carry, Z.
// - Watchdog clear sets expiry and sleep flags, clears prescaler if assigned.
// - Decrement file in place; zero flag updated.
// - Decrement file, no flags; skip next instruction when result is zero.
// - Increment file in place; zero flag updated.
// - Increment file, no flags; skip next instruction when result is zero.
// - Rotate file left or right through carry; only carry changes.
// - Subtract accumulator from file, borrow in unless disabled; C, nibble carry, Z.
// - Swap file nibbles in place; flags untouched.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "ald_map.vh"

module ald_core
#(
  parameter [7:0] DIV_ALT = `ALD_DIV_ALT
)
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        watchdog_clear,
  output wire        prescaler_clear
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_READ = 3'b010;
  localparam [2:0] S_EXEC = 3'b100;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [2:0]  state_q;
  reg  [11:0] instr_q;
  reg  [7:0]  acc_q;
  reg         c_q;
  reg         nibble_carry_flag_q;
  reg         z_q;
  reg         sleep_flag_q;
  reg         watchdog_expiry_flag_q;
  reg         skip_pend_q;
  reg  [11:0] config_word_q;
  reg         carry_in_disable_q;
  reg         psa_q;
  reg  [4:0]  faddr_q;
  reg  [7:0]  div_cnt_q;
  reg         pready_q;
  reg         pslverr_q;
  reg  [31:0] prdata_q;
  reg         rd_wait_q;
  reg         wdt_clr_q;
  reg         psc_clr_q;
  reg  [31:0] rd_val;
  reg         hit;
  reg         ready_ok;

  wire [7:0]  ram_rdata;
  wire [7:0]  alu_res;
  wire        alu_c;
  wire        alu_dc;
  wire        alu_z;
  wire        alu_wr_file;
  wire        alu_wr_acc;
  wire        alu_upd_z;
  wire        alu_upd_c;
  wire        alu_upd_dc;
  wire        alu_skip;
  wire        alu_wdt;

  wire        st_idle = state_q[0];
  wire        st_read = state_q[1];
  wire        st_exec = state_q[2];
  wire        acc_ph  = psel & penable;
  wire        wr_done = acc_ph & pready_q & pwrite;

  // ****************************************************************
  // Instruction clock
  // ****************************************************************
  wire tick = ~config_word_q[`ALD_CFG_DIV] | (div_cnt_q == DIV_ALT - 8'h01);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt_q <= 8'h00;
    else if (tick)
      div_cnt_q <= 8'h00;
    else
      div_cnt_q <= div_cnt_q + 8'h01;
  end

  // ****************************************************************
  // Commit of one instruction
  // ****************************************************************
  wire commit   = st_exec & tick;
  wire do_exec  = commit & ~skip_pend_q;
  wire ram_we   = (do_exec & alu_wr_file) |
                  (wr_done & st_idle & (paddr == `ALD_OFF_FDATA));
  wire [4:0] ram_addr  = st_idle ? faddr_q : instr_q[4:0];
  wire [7:0] ram_wdata = st_idle ? pwdata[7:0] : alu_res;

  ald_file_ram
  #(
    .AW (5),
    .DW (8)
  )
  u_ram
  (
    .clk   (pclk),
    .we    (ram_we),
    .addr  (ram_addr),
    .wdata (ram_wdata),
    .rdata (ram_rdata)
  );

  ald_alu u_alu
  (
    .instr   (instr_q),
    .fval    (ram_rdata),
    .wval    (acc_q),
    .c_in    (c_q),
    .cin_dis (carry_in_disable_q),
    .res     (alu_res),
    .c_out   (alu_c),
    .dc_out  (alu_dc),
    .z_out   (alu_z),
    .wr_file (alu_wr_file),
    .wr_acc  (alu_wr_acc),
    .upd_z   (alu_upd_z),
    .upd_c   (alu_upd_c),
    .upd_dc  (alu_upd_dc),
    .skip    (alu_skip),
    .wdt_clr (alu_wdt)
  );

  // ****************************************************************
  // Register decode and read mux
  // ****************************************************************
  always @*
  begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      `ALD_OFF_INSTR:  rd_val = {15'h0000, ~st_idle, 4'h0, instr_q};
      `ALD_OFF_ACC:    rd_val = {24'h000000, acc_q};
      `ALD_OFF_STATUS: rd_val = {26'h0000000, skip_pend_q, watchdog_expiry_flag_q,
                                 sleep_flag_q, z_q, nibble_carry_flag_q, c_q};
      `ALD_OFF_CONFIG: rd_val = {20'h00000, config_word_q};
      `ALD_OFF_EXTCFG: rd_val = {30'h00000000, psa_q, carry_in_disable_q};
      `ALD_OFF_FADDR:  rd_val = {27'h0000000, faddr_q};
      `ALD_OFF_FDATA:  rd_val = {24'h000000, ram_rdata};
      default:         hit = 1'b0;
    endcase
  end

  // File data needs the core idle and, for reads, one cycle of RAM latency
  always @*
  begin
    ready_ok = 1'b1;
    if (paddr == `ALD_OFF_FDATA)
      ready_ok = st_idle & (pwrite | rd_wait_q);
    else if ((paddr == `ALD_OFF_INSTR) && pwrite)
      ready_ok = st_idle;
  end

  // ****************************************************************
  // APB slave handshake
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      rd_wait_q <= 1'b0;
    end
    else
    begin
      pready_q  <= acc_ph & ~pready_q & ready_ok;
      pslverr_q <= acc_ph & ~pready_q & ready_ok & ~hit;
      if (acc_ph & ~pready_q & ready_ok & ~pwrite)
        prdata_q <= rd_val;
      if (acc_ph & ~pready_q & ~pwrite & st_idle & (paddr == `ALD_OFF_FDATA))
        rd_wait_q <= ~rd_wait_q;
      else
        rd_wait_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Sequencer, accumulator and flags
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q                <= S_IDLE;
      instr_q                <= `ALD_INSTR_RST;
      acc_q                  <= `ALD_ACC_RST;
      c_q                    <= 1'b0;
      nibble_carry_flag_q    <= 1'b0;
      z_q                    <= 1'b0;
      sleep_flag_q           <= 1'b0;
      watchdog_expiry_flag_q <= 1'b0;
      skip_pend_q            <= 1'b0;
      config_word_q          <= `ALD_CFG_RST;
      carry_in_disable_q     <= 1'b0;
      psa_q                  <= 1'b0;
      faddr_q                <= 5'h00;
      wdt_clr_q              <= 1'b0;
      psc_clr_q              <= 1'b0;
    end
    else
    begin
      wdt_clr_q <= 1'b0;
      psc_clr_q <= 1'b0;
      // Software writes first; a commit in the same cycle overrides
      if (wr_done)
      begin
        case (paddr)
          `ALD_OFF_ACC:    acc_q <= pwdata[7:0];
          `ALD_OFF_STATUS:
          begin
            c_q                    <= pwdata[`ALD_ST_C];
            nibble_carry_flag_q    <= pwdata[`ALD_ST_NCARRY];
            z_q                    <= pwdata[`ALD_ST_Z];
            sleep_flag_q           <= pwdata[`ALD_ST_SLEEP];
            watchdog_expiry_flag_q <= pwdata[`ALD_ST_EXPIRY];
          end
          `ALD_OFF_CONFIG: config_word_q <= pwdata[11:0];
          `ALD_OFF_EXTCFG:
          begin
            carry_in_disable_q <= pwdata[`ALD_EXT_CID];
            psa_q              <= pwdata[`ALD_EXT_PSA];
          end
          `ALD_OFF_FADDR:  faddr_q <= pwdata[4:0];
          default:         faddr_q <= faddr_q;
        endcase
      end
      case (state_q)
        S_IDLE:
        begin
          if (wr_done && (paddr == `ALD_OFF_INSTR))
          begin
            instr_q <= pwdata[11:0];
            state_q <= S_READ;
          end
        end
        S_READ:
          state_q <= S_EXEC;
        S_EXEC:
        begin
          if (tick)
            state_q <= S_IDLE;
          if (commit && skip_pend_q)
            skip_pend_q <= 1'b0;
          if (do_exec)
          begin
            if (alu_wr_acc)
              acc_q <= alu_res;
            if (alu_upd_z)
              z_q <= alu_z;
            if (alu_upd_c)
              c_q <= alu_c;
            if (alu_upd_dc)
              nibble_carry_flag_q <= alu_dc;
            if (alu_skip)
              skip_pend_q <= 1'b1;
            if (alu_wdt)
            begin
              watchdog_expiry_flag_q <= 1'b1;
              sleep_flag_q           <= 1'b1;
              wdt_clr_q              <= 1'b1;
              psc_clr_q              <= psa_q;
            end
          end
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign watchdog_clear  = wdt_clr_q;
  assign prescaler_clear = psc_clr_q;

endmodule // ald_core

/* hdl/ald_file_ram.v */
`timescale 1ns/1ps

module ald_file_ram
#(
  parameter AW = 5,
  parameter DW = 8
)
(
  input  wire          clk,
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output wire [DW-1:0] rdata
);

  reg [DW-1:0] mem_r [0:(1<<AW)-1];
  reg [DW-1:0] rdata_q;

  // Registered read, old data on a same-edge write
  always @(posedge clk)
  begin
    if (we)
      mem_r[addr] <= wdata;
    rdata_q <= mem_r[addr];
  end

  assign rdata = rdata_q;

endmodule // ald_file_ram

/* hdl/ald_map.vh */
`ifndef ALD_MAP_VH
`define ALD_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ALD_OFF_INSTR   8'h00
`define ALD_OFF_ACC     8'h04
`define ALD_OFF_STATUS  8'h08
`define ALD_OFF_CONFIG  8'h0c
`define ALD_OFF_EXTCFG  8'h10
`define ALD_OFF_FADDR   8'h14
`define ALD_OFF_FDATA   8'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define ALD_ST_C        0
`define ALD_ST_NCARRY   1
`define ALD_ST_Z        2
`define ALD_ST_SLEEP    3
`define ALD_ST_EXPIRY   4
`define ALD_ST_SKIP     5
`define ALD_INSTR_BUSY  16
`define ALD_CFG_DIV     11
`define ALD_EXT_CID     0
`define ALD_EXT_PSA     1

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define ALD_CFG_RST     12'h000
`define ALD_EXT_RST     2'h0
`define ALD_ACC_RST     8'h00
`define ALD_INSTR_RST   12'h000
`define ALD_DIV_ALT     8'h04

// ****************************************************************
// Opcodes: literal group (bits 11:8), file group (bits 11:5)
// ****************************************************************
`define ALD_OP_ANDL     4'he
`define ALD_OP_ORL      4'hd
`define ALD_OP_XORL     4'hf
`define ALD_OP_CLRWDT   12'h004
`define ALD_OP_ANDF     7'h0b
`define ALD_OP_ANDW     7'h0a
`define ALD_OP_NOTF     7'h13
`define ALD_OP_ORF      7'h09
`define ALD_OP_ORW      7'h08
`define ALD_OP_XORF     7'h0d
`define ALD_OP_XORW     7'h0c
`define ALD_OP_ADDF     7'h0f
`define ALD_OP_ADDW     7'h0e
`define ALD_OP_DECF     7'h07
`define ALD_OP_DECSKIP  7'h17
`define ALD_OP_INCF     7'h15
`define ALD_OP_INCSKIP  7'h1f
`define ALD_OP_RLF      7'h1b
`define ALD_OP_RRF      7'h19
`define ALD_OP_SUBF     7'h05
`define ALD_OP_SWAPF    7'h1d

`endif

/* testbench/ald_core_props.sv */
`timescale 1ns/1ps

module ald_core_props
#(
  parameter [7:0] DIV_ALT = 8'h04
)
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        watchdog_clear,
  input wire        prescaler_clear
);
  // ****************************************************************
  // Shadow of what software wrote
  // ****************************************************************
  reg  [11:0] last_q;
  reg         ext1_q;
  reg         cfg11_q;
  wire        wr_done;

  assign wr_done = psel && penable && pready && pwrite && !pslverr;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_q  <= 12'h000;
      ext1_q  <= 1'b0;
      cfg11_q <= 1'b0;
    end
    else if (wr_done)
    begin
      if (paddr == 8'h00)
        last_q <= pwdata[11:0];
      if (paddr == 8'h10)
        ext1_q <= pwdata[1];
      if (paddr == 8'h0c)
        cfg11_q <= pwdata[11];
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready held for more than one cycle");
  chk_ready_bound: assert property (psel && penable |-> ##[0:12] pready)
    else $error("transfer not answered in time");
  chk_err_map: assert property (pready |->
    pslverr == (paddr > 8'h18 || paddr[1:0] != 2'b00))
    else $error("slave error does not match address map");
  chk_wdt_pulse: assert property (watchdog_clear |=> !watchdog_clear)
    else $error("watchdog clear longer than one cycle");
  chk_presc_pair: assert property (prescaler_clear |-> watchdog_clear && ext1_q)
    else $error("prescaler clear without assigned watchdog clear");
  chk_presc_when: assert property (watchdog_clear && ext1_q |-> prescaler_clear)
    else $error("assigned prescaler not cleared");
  chk_wdt_cause: assert property (watchdog_clear |-> last_q == 12'h004)
    else $error("watchdog clear from another opcode");
  chk_instr_fast: assert property (psel && !penable && paddr == 8'h00
    && !cfg11_q |-> ##[1:4] pready)
    else $error("undivided instruction access too slow");
endmodule // ald_core_props

bind ald_core ald_core_props #(.DIV_ALT(DIV_ALT)) u_props
(
  .pclk            (pclk),
  .presetn         (presetn),
  .psel            (psel),
  .penable         (penable),
  .pwrite          (pwrite),
  .paddr           (paddr),
  .pwdata          (pwdata),
  .prdata          (prdata),
  .pready          (pready),
  .pslverr         (pslverr),
  .watchdog_clear  (watchdog_clear),
  .prescaler_clear (prescaler_clear)
);

/* testbench/alu_logic_arith_decode_tb.sv */
`timescale 1ns/1ps

module alu_logic_arith_decode_tb;
  reg         pclk;
  reg         presetn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  reg  [31:0] rdat;
  reg         rerr;
  reg         cid;
  integer     bad_count;
  integer     n_compared;
  integer     i;
  wire        wclr;
  wire        pclr;
  integer     n_wdt;
  integer     n_psc;

  always @(posedge pclk)
  begin
    if (wclr)
      n_wdt <= n_wdt + 1;
    if (pclr)
      n_psc <= n_psc + 1;
  end

  ald_core u_dut
  (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .watchdog_clear  (wclr),
    .prescaler_clear (pclr)
  );

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ****************************************************************
  // Bus and checking tasks
  // ****************************************************************
  task end_of_test;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 40)
      begin
        @(posedge pclk);
        n = n + 1;
      end
      if (n >= 40)
      begin
        bad_count = bad_count + 1;
        end_of_test;
      end
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Expected {acc, file, skip, status[4:0]} after one instruction
  function [21:0] ref_op(input [11:0] op, input [7:0] w, input [7:0] f, input [4:0] s);
    reg [8:0] r;
    reg [4:0] h;
    reg [7:0] b;
    reg       ci, tw, tf, zu, sk;
    reg [4:0] so;
    begin
      b  = (op[11:5] == 7'h05) ? ~w : w;
      ci = cid ? (op[11:5] == 7'h05) : s[0];
      r  = f + b + ci;
      h  = f[3:0] + b[3:0] + ci;
      so = s; tw = 1'b0; tf = 1'b1; zu = 1'b1; sk = 1'b0;
      case (op[11:8])
        4'he: begin r = w & op[7:0]; tw = 1'b1; tf = 1'b0; end
        4'hd: begin r = w | op[7:0]; tw = 1'b1; tf = 1'b0; end
        4'hf: begin r = w ^ op[7:0]; tw = 1'b1; tf = 1'b0; end
        default: case (op[11:5])
          7'h0b: r = f & w;
          7'h0a: begin r = f & w; tw = 1'b1; tf = 1'b0; end
          7'h13: r = ~f;
          7'h09: r = f | w;
          7'h08: begin r = f | w; tw = 1'b1; tf = 1'b0; end
          7'h0d: r = f ^ w;
          7'h0c: begin r = f ^ w; tw = 1'b1; tf = 1'b0; end
          7'h0f, 7'h05: so[1:0] = {h[4], r[8]};
          7'h0e: begin so[1:0] = {h[4], r[8]}; tw = 1'b1; tf = 1'b0; end
          7'h07: r = f - 8'h01;
          7'h17: begin r = f - 8'h01; zu = 1'b0; sk = (r[7:0] == 8'h00); end
          7'h15: r = f + 8'h01;
          7'h1f: begin r = f + 8'h01; zu = 1'b0; sk = (r[7:0] == 8'h00); end
          7'h1b: begin r = {f[6:0], s[0]}; so[0] = f[7]; zu = 1'b0; end
          7'h19: begin r = {s[0], f[7:1]}; so[0] = f[0]; zu = 1'b0; end
          7'h1d: begin r = {f[3:0], f[7:4]}; zu = 1'b0; end
          default: begin so[4:3] = 2'b11; zu = 1'b0; tf = 1'b0; end
        endcase
      endcase
      if (zu)
        so[2] = (r[7:0] == 8'h00);
      ref_op = {tw ? r[7:0] : w, tf ? r[7:0] : f, sk, so};
    end
  endfunction

  task t(input [11:0] op, input [7:0] w, input [7:0] f, input [4:0] s);
    reg [21:0] e;
    begin
      e = ref_op(op, w, f, s);
      apb(1'b1, 8'h14, {27'h0, op[4:0]});
      apb(1'b1, 8'h18, {24'h0, f});
      apb(1'b1, 8'h04, {24'h0, w});
      apb(1'b1, 8'h08, {27'h0, s});
      apb(1'b1, 8'h00, {20'h0, op});
      apb(1'b0, 8'h18, 32'h0);
      chk(rdat, {24'h0, e[13:6]});
      apb(1'b0, 8'h04, 32'h0);
      chk(rdat, {24'h0, e[21:14]});
      apb(1'b0, 8'h08, 32'h0);
      chk(rdat, {26'h0, e[5:0]});
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; cid = 1'b0; bad_count = 0; n_compared = 0;
    n_wdt = 0;
    n_psc = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 6; i = i + 1)
    begin
      apb(1'b0, {i[5:0], 2'b00}, 32'h0);
      chk(rdat, 32'h0);
    end
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    t({7'h0b, 5'h01}, 8'h0f, 8'h3c, 5'h00);
    t({7'h0a, 5'h02}, 8'hf0, 8'h0f, 5'h00);
    t(12'he5a, 8'hff, 8'h00, 5'h04);
    t({7'h13, 5'h1f}, 8'h00, 8'hff, 5'h00);
    t({7'h09, 5'h03}, 8'h00, 8'h00, 5'h00);
    t({7'h08, 5'h04}, 8'h01, 8'h80, 5'h04);
    t(12'hd00, 8'h00, 8'h55, 5'h00);
    t({7'h0d, 5'h05}, 8'h5a, 8'h5a, 5'h00);
    t({7'h0c, 5'h06}, 8'h33, 8'h0f, 5'h04);
    t(12'hfff, 8'h0f, 8'h00, 5'h00);
    t({7'h0f, 5'h07}, 8'h8f, 8'h71, 5'h01);
    t({7'h0e, 5'h08}, 8'h08, 8'h08, 5'h00);
    t(12'h004, 8'h12, 8'h34, 5'h00);
    t({7'h07, 5'h09}, 8'h00, 8'h01, 5'h00);
    t({7'h17, 5'h0a}, 8'h00, 8'h05, 5'h07);
    t({7'h1b, 5'h0b}, 8'h00, 8'h81, 5'h00);
    t({7'h19, 5'h0c}, 8'h00, 8'h01, 5'h01);
    t({7'h05, 5'h0d}, 8'h06, 8'h05, 5'h01);
    t({7'h05, 5'h0e}, 8'h01, 8'h10, 5'h00);
    t({7'h1d, 5'h0f}, 8'h00, 8'ha5, 5'h07);
    for (i = 0; i < 2; i = i + 1)
    begin
      t(i ? {7'h1f, 5'h04} : {7'h17, 5'h04}, 8'h00, i ? 8'hff : 8'h01, 5'h00);
      apb(1'b1, 8'h00, {20'h0, 7'h15, 5'h04});
      apb(1'b0, 8'h18, 32'h0);
      chk(rdat, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk(rdat, 32'h0);
    end
    t({7'h15, 5'h04}, 8'h00, 8'hff, 5'h00);
    t({7'h1f, 5'h11}, 8'h00, 8'h10, 5'h00);
    apb(1'b1, 8'h10, 32'h1);
    cid = 1'b1;
    t({7'h0f, 5'h12}, 8'h01, 8'h01, 5'h01);
    t({7'h05, 5'h13}, 8'h01, 8'h01, 5'h00);
    apb(1'b1, 8'h10, 32'h2);
    cid = 1'b0;
    t(12'h004, 8'h00, 8'h00, 5'h07);
    apb(1'b1, 8'h0c, 32'h800);
    t({7'h0e, 5'h14}, 8'hff, 8'h01, 5'h01);
    apb(1'b1, 8'h0c, 32'h0);
    t({7'h0b, 5'h15}, 8'hc3, 8'h3c, 5'h00);
    chk(n_wdt, 32'h2);
    chk(n_psc, 32'h1);
    end_of_test;
  end
endmodule // alu_logic_arith_decode_tb
